// File: logic/calse_exec.sv
// Notes on behaviour
// - Add-with-carry sums destination, source and carry; word or byte width.
// - Add-with-carry sets zero only if result zero and zero was already set.
// - Add and AND set end-of-table when source is most negative value.
// - Add-with-carry sets overflow when the signed result does not fit.
// - Add-with-carry sets carry on carry out of the top bit.
// - Add, AND and shift copy result top bit into negative flag.
// - Word add-with-carry opcodes 18, 10, 14, 16, 12.
// - Byte add-with-carry opcodes 19, 11, 15, 17, 13; 17 ignores second byte.
// - Word AND opcodes 68, 60, 64, 62, 66.
// - Byte AND opcodes 69, 61, 65, 67, 63; 67 ignores second byte.
// - AND writes the conjunction and always clears overflow and carry.
// - Signed right shift fills vacated upper bits with the sign bit.
// - Shift count 0 to 15; register count uses its low four bits.
// - Shift carry holds last bit shifted out; zero count clears it.
// - Shift overflow flags any one leaving carry; zero count clears it.
// - Uninterruptible sequence blocks interrupts and class A traps for next 1-4 instructions.
// - Uninterruptible sequence acts at once, no padding instructions needed.
// - Each protected instruction counts once, whatever its cycle count.
// - Any instruction allowed inside; the sequence instruction leaves flags alone.
// - Single-bit AND writes source bit AND destination bit into destination bit.
// - Status word as destination takes the result by format, not flags.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`include "calse_defs.svh"
module calse_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core side
  input wire logic instr_done_i,
  input wire logic class_b_trap_i,
  output logic irq_block_o,
  output calse_pkg::calse_flags_type flags_o,
  output logic [15:0] result_o
);

  // Bus state
  logic ack;
  logic [31:0] dat;
  logic next_ack;
  logic [31:0] next_dat;

  // Execution state
  logic [15:0] opa;
  logic [15:0] opb;
  logic [31:0] cmd;
  logic [15:0] processor_status_word;
  logic [15:0] res;
  logic illegal;
  logic [15:0] next_opa;
  logic [15:0] next_opb;
  logic [31:0] next_cmd;
  logic [15:0] next_psw;
  logic [15:0] next_res;
  logic next_illegal;

  // Protected sequence state
  logic [2:0] cnt;
  logic [2:0] next_cnt;

  // Decode and datapath
  logic wr_acc;
  logic exec;
  logic [31:0] cmd_new;
  logic [7:0] opc;
  logic [7:0] b2;
  logic bad_op;
  calse_pkg::calse_op_type op;
  calse_pkg::calse_flags_type fin;
  calse_pkg::calse_flags_type fout;
  logic [15:0] alu;
  logic [16:0] sum_w;
  logic [8:0] sum_b;
  logic [15:0] and_w;
  logic [15:0] sh_res;
  logic sh_c;
  logic sh_v;
  logic [3:0] qpos;
  logic [3:0] zpos;
  logic [15:0] bit_word;
  logic src_bit;
  logic dst_bit;
  logic psw_dst;
  logic [2:0] atom_cnt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // A write commits on the edge that the master sees the acknowledge
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ack;
  assign exec = wr_acc & (wb_adr_i == `CALSE_ADR_CMD) & (|wb_sel_i);
  assign cmd_new = merge(cmd, wb_dat_i, wb_sel_i);
  assign opc = cmd_new[`CALSE_CMD_OP_MSB:0];
  assign b2 = cmd_new[`CALSE_CMD_B2_MSB:`CALSE_CMD_B2_LSB];
  assign qpos = cmd_new[`CALSE_CMD_QPOS_MSB:`CALSE_CMD_QPOS_LSB];
  assign zpos = cmd_new[`CALSE_CMD_ZPOS_MSB:`CALSE_CMD_ZPOS_LSB];
  assign psw_dst = cmd_new[`CALSE_CMD_PSWDST];
  assign fin.e = processor_status_word[`CALSE_PSW_E];
  assign fin.z = processor_status_word[`CALSE_PSW_Z];
  assign fin.v = processor_status_word[`CALSE_PSW_V];
  assign fin.c = processor_status_word[`CALSE_PSW_C];
  assign fin.n = processor_status_word[`CALSE_PSW_N];

  // Opcode decode
  always_comb begin
    op.kind = calse_pkg::CALSE_K_NONE;
    op.byte_op = 1'b0;
    op.src = opb;
    op.count = opb[3:0];
    bad_op = 1'b0;
    case (opc)
      `CALSE_OP_WORD_ADD_WITH_CARRY_SHORT: begin
        op.kind = calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY;
        if (!b2[`CALSE_B2_INDIRECT]) begin
          op.src = {13'h0000, b2[`CALSE_B2_DATA3_MSB:0]};
        end
      end
      `CALSE_OP_WORD_ADD_WITH_CARRY_RR, `CALSE_OP_WORD_ADD_WITH_CARRY_MR, `CALSE_OP_WORD_ADD_WITH_CARRY_RI, `CALSE_OP_WORD_ADD_WITH_CARRY_RM: begin
        op.kind = calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY;
      end
      `CALSE_OP_BYTE_ADD_WITH_CARRY_SHORT: begin
        op.kind = calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY;
        op.byte_op = 1'b1;
        if (!b2[`CALSE_B2_INDIRECT]) begin
          op.src = {13'h0000, b2[`CALSE_B2_DATA3_MSB:0]};
        end
      end
      `CALSE_OP_BYTE_ADD_WITH_CARRY_RR, `CALSE_OP_BYTE_ADD_WITH_CARRY_MR, `CALSE_OP_BYTE_ADD_WITH_CARRY_RM: begin
        op.kind = calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY;
        op.byte_op = 1'b1;
      end
      `CALSE_OP_BYTE_ADD_WITH_CARRY_RI: begin
        op.kind = calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY;
        op.byte_op = 1'b1;
        op.src = {8'h00, opb[7:0]};
      end
      `CALSE_OP_AND_SHORT: begin
        op.kind = calse_pkg::CALSE_K_AND;
        if (!b2[`CALSE_B2_INDIRECT]) begin
          op.src = {13'h0000, b2[`CALSE_B2_DATA3_MSB:0]};
        end
      end
      `CALSE_OP_AND_RR, `CALSE_OP_AND_MR, `CALSE_OP_AND_RI, `CALSE_OP_AND_RM: begin
        op.kind = calse_pkg::CALSE_K_AND;
      end
      `CALSE_OP_BYTE_BITWISE_CONJUNCTION_SHORT: begin
        op.kind = calse_pkg::CALSE_K_AND;
        op.byte_op = 1'b1;
        if (!b2[`CALSE_B2_INDIRECT]) begin
          op.src = {13'h0000, b2[`CALSE_B2_DATA3_MSB:0]};
        end
      end
      `CALSE_OP_BYTE_BITWISE_CONJUNCTION_RR, `CALSE_OP_BYTE_BITWISE_CONJUNCTION_MR, `CALSE_OP_BYTE_BITWISE_CONJUNCTION_RM: begin
        op.kind = calse_pkg::CALSE_K_AND;
        op.byte_op = 1'b1;
      end
      `CALSE_OP_BYTE_BITWISE_CONJUNCTION_RI: begin
        op.kind = calse_pkg::CALSE_K_AND;
        op.byte_op = 1'b1;
        op.src = {8'h00, opb[7:0]};
      end
      `CALSE_OP_SIGNED_RIGHT_SHIFT_IMM: begin
        op.kind = calse_pkg::CALSE_K_SIGNED_RIGHT_SHIFT;
        op.count = b2[`CALSE_B2_CNT_MSB:`CALSE_B2_CNT_LSB];
      end
      `CALSE_OP_SIGNED_RIGHT_SHIFT_REG: begin
        op.kind = calse_pkg::CALSE_K_SIGNED_RIGHT_SHIFT;
        op.count = opb[3:0];
      end
      `CALSE_OP_UNINTERRUPTIBLE_SEQUENCE: begin
        op.kind = calse_pkg::CALSE_K_ATOM;
      end
      `CALSE_OP_BAND: begin
        op.kind = calse_pkg::CALSE_K_BAND;
      end
      default: begin
        bad_op = 1'b1;
      end
    endcase
  end

  calse_signed_right_shift #(
    .WIDTH(16),
    .CW(4)
  ) u_signed_right_shift (
    .value_i(opa),
    .count_i(op.count),
    .result_o(sh_res),
    .carry_o(sh_c),
    .round_o(sh_v)
  );

  // Operand field 0..3 selects one to four protected instructions
  assign atom_cnt = {1'b0, b2[`CALSE_B2_ATOM_MSB:`CALSE_B2_ATOM_LSB]} + 3'h1;
  assign sum_w = {1'b0, opa} + {1'b0, op.src} + {16'h0000, fin.c};
  assign sum_b = {1'b0, opa[7:0]} + {1'b0, op.src[7:0]} + {8'h00, fin.c};
  assign and_w = opa & op.src;
  // Bit operand comes from the status word when that is the target
  assign bit_word = psw_dst ? processor_status_word : opa;
  assign src_bit = opb[qpos];
  assign dst_bit = bit_word[zpos];

  // Result and flag datapath
  always_comb begin
    alu = opa;
    fout = fin;
    case (op.kind)
      calse_pkg::CALSE_K_WORD_ADD_WITH_CARRY: begin
        if (op.byte_op) begin
          alu = {opa[15:8], sum_b[7:0]};
          fout.z = (sum_b[7:0] == 8'h00) & fin.z;
          fout.v = (opa[7] == op.src[7]) & (sum_b[7] != opa[7]);
          fout.c = sum_b[8];
          fout.e = op.src[7:0] == 8'h80;
          fout.n = sum_b[7];
        end else begin
          alu = sum_w[15:0];
          fout.z = (sum_w[15:0] == 16'h0000) & fin.z;
          fout.v = (opa[15] == op.src[15]) & (sum_w[15] != opa[15]);
          fout.c = sum_w[16];
          fout.e = op.src == 16'h8000;
          fout.n = sum_w[15];
        end
      end
      calse_pkg::CALSE_K_AND: begin
        fout.v = 1'b0;
        fout.c = 1'b0;
        if (op.byte_op) begin
          alu = {opa[15:8], and_w[7:0]};
          fout.z = and_w[7:0] == 8'h00;
          fout.e = op.src[7:0] == 8'h80;
          fout.n = and_w[7];
        end else begin
          alu = and_w;
          fout.z = and_w == 16'h0000;
          fout.e = op.src == 16'h8000;
          fout.n = and_w[15];
        end
      end
      calse_pkg::CALSE_K_SIGNED_RIGHT_SHIFT: begin
        alu = sh_res;
        fout.e = 1'b0;
        fout.z = sh_res == 16'h0000;
        fout.c = sh_c;
        fout.v = sh_v;
        fout.n = sh_res[15];
      end
      calse_pkg::CALSE_K_BAND: begin
        alu = bit_word;
        alu[zpos] = src_bit & dst_bit;
        fout.e = 1'b0;
        fout.z = ~(src_bit | dst_bit);
        fout.v = src_bit | dst_bit;
        fout.c = src_bit & dst_bit;
        fout.n = src_bit ^ dst_bit;
      end
      default: begin
        // flags untouched by the sequence instruction
        fout = fin;
      end
    endcase
  end

  // Bus group
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_dat = 32'h0000_0000;
    if (next_ack && !wb_we_i) begin
      if (wb_adr_i == `CALSE_ADR_OPA) begin
        next_dat = {16'h0000, opa};
      end else if (wb_adr_i == `CALSE_ADR_OPB) begin
        next_dat = {16'h0000, opb};
      end else if (wb_adr_i == `CALSE_ADR_CMD) begin
        next_dat = cmd;
      end else if (wb_adr_i == `CALSE_ADR_PSW) begin
        next_dat = {16'h0000, processor_status_word};
      end else if (wb_adr_i == `CALSE_ADR_RES) begin
        next_dat = {16'h0000, res};
      end else if (wb_adr_i == `CALSE_ADR_STAT) begin
        next_dat[`CALSE_STAT_CNT_MSB:0] = cnt;
        next_dat[`CALSE_STAT_ILLEGAL] = illegal;
      end else begin
        next_dat = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      dat <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  // Execution group
  always_comb begin
    next_opa = opa;
    next_opb = opb;
    next_cmd = cmd;
    next_psw = processor_status_word;
    next_res = res;
    next_illegal = illegal;
    if (wr_acc && wb_adr_i == `CALSE_ADR_OPA) begin
      next_opa = 16'(merge({16'h0000, opa}, wb_dat_i, wb_sel_i));
    end else if (wr_acc && wb_adr_i == `CALSE_ADR_OPB) begin
      next_opb = 16'(merge({16'h0000, opb}, wb_dat_i, wb_sel_i));
    end else if (wr_acc && wb_adr_i == `CALSE_ADR_PSW) begin
      next_psw = 16'(merge({16'h0000, processor_status_word}, wb_dat_i, wb_sel_i));
    end
    // any command may run during a protected sequence
    if (exec) begin
      next_cmd = cmd_new;
      next_illegal = bad_op;
      if (!bad_op && op.kind != calse_pkg::CALSE_K_ATOM) begin
        next_res = alu;
        if (psw_dst) begin
          // status word written by format, flags not meaningful
          if (op.kind == calse_pkg::CALSE_K_BAND || !op.byte_op) begin
            next_psw = alu;
          end else begin
            next_psw = {8'h00, alu[7:0]};
          end
        end else begin
          next_opa = alu;
          next_psw[`CALSE_PSW_E] = fout.e;
          next_psw[`CALSE_PSW_Z] = fout.z;
          next_psw[`CALSE_PSW_V] = fout.v;
          next_psw[`CALSE_PSW_C] = fout.c;
          next_psw[`CALSE_PSW_N] = fout.n;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opa <= `CALSE_RST_WORD;
      opb <= `CALSE_RST_WORD;
      cmd <= `CALSE_RST_CMD;
      processor_status_word <= `CALSE_RST_WORD;
      res <= `CALSE_RST_WORD;
      illegal <= 1'b0;
    end else begin
      opa <= next_opa;
      opb <= next_opb;
      cmd <= next_cmd;
      processor_status_word <= next_psw;
      res <= next_res;
      illegal <= next_illegal;
    end
  end

  // Protected sequence group
  always_comb begin
    next_cnt = cnt;
    if (exec && !bad_op && op.kind == calse_pkg::CALSE_K_ATOM) begin
      // blocking starts on the very next cycle
      next_cnt = atom_cnt;
    end else if (class_b_trap_i) begin
      // class B trap ends the sequence
      next_cnt = `CALSE_RST_CNT;
    end else if (instr_done_i && cnt != `CALSE_RST_CNT) begin
      next_cnt = cnt - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= `CALSE_RST_CNT;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat;
  // interrupts, event transfers and class A traps held off
  assign irq_block_o = cnt != `CALSE_RST_CNT;
  assign result_o = res;
  assign flags_o = fin;

endmodule

// File: logic/calse_defs.svh
`ifndef CALSE_DEFS_SVH
`define CALSE_DEFS_SVH

// Register byte offsets
`define CALSE_ADR_OPA 8'h00
`define CALSE_ADR_OPB 8'h04
`define CALSE_ADR_CMD 8'h08
`define CALSE_ADR_PSW 8'h0c
`define CALSE_ADR_RES 8'h10
`define CALSE_ADR_STAT 8'h14

// Reset values
`define CALSE_RST_WORD 16'h0000
`define CALSE_RST_CMD 32'h0000_0000
`define CALSE_RST_CNT 3'h0

// Condition flag positions in the processor status word
`define CALSE_PSW_N 0
`define CALSE_PSW_C 1
`define CALSE_PSW_V 2
`define CALSE_PSW_Z 3
`define CALSE_PSW_E 4

// Command register fields
`define CALSE_CMD_OP_MSB 7
`define CALSE_CMD_B2_LSB 8
`define CALSE_CMD_B2_MSB 15
`define CALSE_CMD_QPOS_LSB 16
`define CALSE_CMD_QPOS_MSB 19
`define CALSE_CMD_ZPOS_LSB 20
`define CALSE_CMD_ZPOS_MSB 23
`define CALSE_CMD_PSWDST 24

// Fields inside the second instruction byte
`define CALSE_B2_INDIRECT 3
`define CALSE_B2_DATA3_MSB 2
`define CALSE_B2_CNT_LSB 4
`define CALSE_B2_CNT_MSB 7
`define CALSE_B2_ATOM_LSB 4
`define CALSE_B2_ATOM_MSB 5

// Status register fields
`define CALSE_STAT_CNT_MSB 2
`define CALSE_STAT_ILLEGAL 8

// Opcodes
`define CALSE_OP_WORD_ADD_WITH_CARRY_SHORT 8'h18
`define CALSE_OP_WORD_ADD_WITH_CARRY_RR 8'h10
`define CALSE_OP_WORD_ADD_WITH_CARRY_MR 8'h14
`define CALSE_OP_WORD_ADD_WITH_CARRY_RI 8'h16
`define CALSE_OP_WORD_ADD_WITH_CARRY_RM 8'h12
`define CALSE_OP_BYTE_ADD_WITH_CARRY_SHORT 8'h19
`define CALSE_OP_BYTE_ADD_WITH_CARRY_RR 8'h11
`define CALSE_OP_BYTE_ADD_WITH_CARRY_MR 8'h15
`define CALSE_OP_BYTE_ADD_WITH_CARRY_RI 8'h17
`define CALSE_OP_BYTE_ADD_WITH_CARRY_RM 8'h13
`define CALSE_OP_AND_SHORT 8'h68
`define CALSE_OP_AND_RR 8'h60
`define CALSE_OP_AND_MR 8'h64
`define CALSE_OP_AND_RI 8'h66
`define CALSE_OP_AND_RM 8'h62
`define CALSE_OP_BYTE_BITWISE_CONJUNCTION_SHORT 8'h69
`define CALSE_OP_BYTE_BITWISE_CONJUNCTION_RR 8'h61
`define CALSE_OP_BYTE_BITWISE_CONJUNCTION_MR 8'h65
`define CALSE_OP_BYTE_BITWISE_CONJUNCTION_RI 8'h67
`define CALSE_OP_BYTE_BITWISE_CONJUNCTION_RM 8'h63
`define CALSE_OP_SIGNED_RIGHT_SHIFT_IMM 8'hbc
`define CALSE_OP_SIGNED_RIGHT_SHIFT_REG 8'hac
`define CALSE_OP_UNINTERRUPTIBLE_SEQUENCE 8'hd1
`define CALSE_OP_BAND 8'h6a

`endif

// File: logic/calse_pkg.sv
package calse_pkg;

  typedef enum logic [2:0] {
    CALSE_K_NONE = 3'b000,
    CALSE_K_WORD_ADD_WITH_CARRY = 3'b001,
    CALSE_K_AND = 3'b010,
    CALSE_K_SIGNED_RIGHT_SHIFT = 3'b011,
    CALSE_K_ATOM = 3'b100,
    CALSE_K_BAND = 3'b101
  } calse_kind_type;

  typedef struct packed {
    logic e;
    logic z;
    logic v;
    logic c;
    logic n;
  } calse_flags_type;

  typedef struct packed {
    calse_kind_type kind;
    logic byte_op;
    logic [15:0] src;
    logic [3:0] count;
  } calse_op_type;

endpackage

// File: logic/calse_signed_right_shift.sv
`timescale 1ns/1ns
module calse_signed_right_shift #(
  parameter int WIDTH = 16,
  parameter int CW = 4
) (
  // Operand and count
  input wire logic [WIDTH-1:0] value_i,
  input wire logic [CW-1:0] count_i,
  // Shift results
  output logic [WIDTH-1:0] result_o,
  output logic carry_o,
  output logic round_o
);

  generate
    if (WIDTH != (1 << CW)) begin : g_bad_width
      $error("calse_signed_right_shift: WIDTH must equal 2**CW");
    end
  endgenerate

  always_comb begin
    result_o = WIDTH'($signed(value_i) >>> count_i);
    carry_o = 1'b0;
    round_o = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      // Last bit out lands in carry; every earlier one passes through it
      if (i + 1 == int'(count_i)) begin
        carry_o = value_i[i];
      end
      if (i + 1 < int'(count_i)) begin
        round_o = round_o | value_i[i];
      end
    end
  end

endmodule

// File: test/calse_exec_properties.sv
`timescale 1ns/1ns
`include "calse_defs.svh"
module calse_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Core side
  input wire logic instr_done_i,
  input wire logic class_b_trap_i,
  input wire logic irq_block_o,
  input wire calse_pkg::calse_flags_type flags_o,
  input wire logic [15:0] result_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_wr;
  // Broad on purpose: any acknowledged command write may reload the count
  assign cmd_wr = wb_ack_o && wb_we_i && wb_adr_i == `CALSE_ADR_CMD;
  sequence s_atom_load;
    cmd_wr && wb_sel_i == 4'hf && wb_dat_i[7:0] == `CALSE_OP_UNINTERRUPTIBLE_SEQUENCE;
  endsequence
  sequence s_atom_one;
    s_atom_load ##0 wb_dat_i[13:12] == 2'b00;
  endsequence
  sequence s_step;
    instr_done_i && !class_b_trap_i && !cmd_wr;
  endsequence
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_atom_now; s_atom_load |=> irq_block_o; endproperty
  property p_atom_one; s_atom_one ##1 s_step |=> !irq_block_o; endproperty
  property p_hold; irq_block_o && !instr_done_i && !class_b_trap_i |=> irq_block_o; endproperty
  property p_trap_end; class_b_trap_i && !cmd_wr |=> !irq_block_o; endproperty
  property p_irq_cause; $rose(irq_block_o) |-> $past(cmd_wr); endproperty
  property p_atom_flags; s_atom_load |=> $stable(flags_o) [*2]; endproperty
  property p_res_quiet; !cmd_wr |=> $stable(result_o); endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero while idle");
  a_atom_now: assert property (p_atom_now) else $error("block not raised at once");
  a_atom_one: assert property (p_atom_one) else $error("single count not ended");
  a_hold: assert property (p_hold) else $error("block dropped without step");
  a_trap_end: assert property (p_trap_end) else $error("trap did not end block");
  a_irq_cause: assert property (p_irq_cause) else $error("block raised without command");
  a_atom_flags: assert property (p_atom_flags) else $error("sequence changed flags");
  a_res_quiet: assert property (p_res_quiet) else $error("result moved without command");
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ns
`include "calse_defs.svh"
module tb_top;
  typedef struct {logic [31:0] e; logic [31:0] m; string n;} calse_note_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic instr_done_i = 1'b0;
  logic class_b_trap_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_block_o;
  calse_pkg::calse_flags_type flags_o;
  logic [15:0] result_o;
  int err_total = 0;
  int comparisons = 0;
  calse_note_type notes[$];
  logic [15:0] m_opa;
  logic [15:0] m_psw;
  logic [7:0] ops [20] = '{8'h18, 8'h10, 8'h14, 8'h16, 8'h12, 8'h19, 8'h11, 8'h15, 8'h17,
    8'h13, 8'h68, 8'h60, 8'h64, 8'h66, 8'h62, 8'h69, 8'h61, 8'h65, 8'h67, 8'h63};

  always #50 clk_i = ~clk_i;

  calse_exec i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_done_i(instr_done_i),
    .class_b_trap_i(class_b_trap_i), .irq_block_o(irq_block_o), .flags_o(flags_o),
    .result_o(result_o)
  );

  task final_report;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read results are judged against the oldest note
  always @(posedge clk_i) begin
    calse_note_type nt;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      comparisons++;
      if ((wb_dat_o & nt.m) !== nt.e) begin
        err_total++;
        $display("BAD %s expected %h seen %h", nt.n, nt.e, wb_dat_o & nt.m);
      end
    end
  end

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("BAD ack expected 1 seen %b", wb_ack_o);
      final_report();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    notes.push_back('{e & m, m, n});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task setup(input logic [15:0] a, input logic [15:0] b, input logic [15:0] p);
    m_opa = a;
    m_psw = p;
    bus(1'b1, `CALSE_ADR_OPA, {16'h0, a}, 4'h3);
    bus(1'b1, `CALSE_ADR_OPB, {16'h0, b}, 4'h3);
    bus(1'b1, `CALSE_ADR_PSW, {16'h0, p}, 4'h3);
  endtask

  task chk;
    rd(`CALSE_ADR_OPA, {16'h0, m_opa}, 32'hffff, "operand");
    rd(`CALSE_ADR_PSW, {16'h0, m_psw}, 32'h1f, "status");
    look("flags port", {11'h0, m_psw[4:0]}, {11'h0, flags_o});
  endtask

  task look(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task pulse(input logic d, input logic t);
    @(posedge clk_i);
    instr_done_i <= d;
    class_b_trap_i <= t;
    @(posedge clk_i);
    instr_done_i <= 1'b0;
    class_b_trap_i <= 1'b0;
  endtask

  // Reference sum or conjunction; returns {e,z,v,c,n,result}
  function automatic logic [20:0] alu(input logic [7:0] op, input logic [15:0] d,
                                      input logic [15:0] s, input logic [4:0] f);
    logic [16:0] sum;
    logic [15:0] w;
    logic cy, ov, top, zz, ez;
    sum = {1'b0, d} + {1'b0, s} + {16'h0, f[1]};
    w = op[6] ? (d & s) : sum[15:0];
    {cy, ov, top, zz, ez} = {sum[16], d[15] == s[15] && w[15] != d[15], w[15], w == 16'h0,
                             s == 16'h8000};
    if (op[0]) begin
      sum = {9'h0, d[7:0]} + {9'h0, s[7:0]} + {16'h0, f[1]};
      w = {d[15:8], op[6] ? (d[7:0] & s[7:0]) : sum[7:0]};
      {cy, ov, top, zz, ez} = {sum[8], d[7] == s[7] && w[7] != d[7], w[7], w[7:0] == 8'h0,
                               s[7:0] == 8'h80};
    end
    if (op[6])
      {cy, ov} = 2'b00;
    else
      zz = zz & f[3];
    return {ez, zz, ov, cy, top, w};
  endfunction

  initial begin
    logic [15:0] a, b, x;
    logic [7:0] op, b2;
    logic [20:0] o;
    logic [3:0] q, z;
    logic v, c, ab;
    void'($urandom(32'h9f7dbec3));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h18, 32'h0, 32'hffffffff, "unmapped");
    bus(1'b1, `CALSE_ADR_RES, 32'hffff, 4'hf);
    rd(`CALSE_ADR_RES, 32'h0, 32'hffffffff, "result reset");
    rd(`CALSE_ADR_STAT, 32'h0, 32'hffffffff, "status reset");
    $display("test reset done");
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 20; i++) begin
        {op, b2, a, b} = {ops[i], 8'($urandom), 16'($urandom), 16'($urandom)};
        if ($urandom_range(3) == 0)
          b = op[0] ? {b[15:8], 8'h80} : 16'h8000;
        x = 16'($urandom_range(31));
        // Second round aims at a zero result so the chained zero flag is exercised
        if (r == 1) begin
          b2[3] = 1'b1;
          b = op[6] ? ~a : 16'h0 - a - {15'h0, x[1]};
        end
        setup(a, b, x);
        if (op[3] && !b2[3])
          b = {13'h0, b2[2:0]};
        exec_cmd({16'h0, b2, op});
        o = alu(op, a, b, m_psw[4:0]);
        m_opa = o[15:0];
        m_psw = {11'h0, o[20:16]};
        chk();
        rd(`CALSE_ADR_RES, {16'h0, o[15:0]}, op[0] ? 32'hff : 32'hffff, "result");
        look("result port", o[15:0], result_o);
      end
    end
    $display("test add and conjunction done");
    for (int k = 0; k < 16; k++) begin
      {a, b, b2} = {16'($urandom), 16'($urandom), 8'($urandom)};
      b[3:0] = 4'(k);
      b2[7:4] = 4'(k);
      setup(a, b, 16'($urandom_range(31)));
      exec_cmd({16'h0, b2, k[0] ? `CALSE_OP_SIGNED_RIGHT_SHIFT_REG : `CALSE_OP_SIGNED_RIGHT_SHIFT_IMM});
      {x, v, c} = {a, 2'b00};
      repeat (k) begin
        v = v | c;
        c = x[0];
        x = {x[15], x[15:1]};
      end
      m_opa = x;
      m_psw = {11'h0, 1'b0, x == 16'h0, v, c, x[15]};
      chk();
    end
    $display("test shift done");
    for (int k = 0; k < 4; k++) begin
      exec_cmd({18'h0, 2'(k), 4'h0, 8'hd1});
      rd(`CALSE_ADR_STAT, 32'(k + 1), 32'h7, "count loaded");
      look("block", 16'h1, {15'h0, irq_block_o});
      repeat (k) pulse(1'b1, 1'b0);
      rd(`CALSE_ADR_STAT, 32'h1, 32'h7, "count left");
      pulse(1'b1, 1'b0);
      pulse(1'b1, 1'b0);
      chk();
      rd(`CALSE_ADR_STAT, 32'h0, 32'h7, "count done");
      look("block end", 16'h0, {15'h0, irq_block_o});
    end
    // Instruction completes in the cycle right after the load
    exec_cmd({18'h0, 2'd0, 4'h0, 8'hd1});
    instr_done_i <= 1'b1;
    @(posedge clk_i);
    instr_done_i <= 1'b0;
    rd(`CALSE_ADR_STAT, 32'h0, 32'h7, "count single");
    exec_cmd({18'h0, 2'd3, 4'h0, 8'hd1});
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    rd(`CALSE_ADR_STAT, 32'h0, 32'h7, "count after trap");
    $display("test sequence done");
    // bit conjunction into operand or status
    for (int i = 0; i < 8; i++) begin
      {a, b, q, z} = {16'($urandom), 16'($urandom), 4'($urandom), 4'($urandom)};
      if (i[0])
        z = 4'($urandom_range(4));
      setup(a, b, 16'($urandom_range(31)));
      exec_cmd({7'h0, i[0], z, q, 8'h00, `CALSE_OP_BAND});
      ab = i[0] ? m_psw[z] : a[z];
      if (i[0])
        m_psw[z] = ab & b[q];
      else begin
        m_opa[z] = ab & b[q];
        m_psw = {11'h0, 1'b0, ~(ab | b[q]), ab | b[q], ab & b[q], ab ^ b[q]};
      end
      chk();
    end
    // add with the status word as target
    for (int j = 0; j < 2; j++) begin
      {a, b} = {16'($urandom), 16'($urandom)};
      setup(a, b, 16'($urandom_range(31)));
      exec_cmd({7'h0, 1'b1, 16'h0, 8'(`CALSE_OP_WORD_ADD_WITH_CARRY_RR + j)});
      x = a + b + {15'h0, m_psw[1]};
      m_psw = j[0] ? {8'h00, x[7:0]} : x;
      chk();
    end
    bus(1'b1, `CALSE_ADR_CMD, 32'h0000_00ff, 4'hf);
    rd(`CALSE_ADR_STAT, 32'h100, 32'h100, "illegal flag");
    bus(1'b1, `CALSE_ADR_CMD, 32'h0000_0060, 4'h0);
    chk();
    $display("test bit and misc done");
    final_report();
  end

  task exec_cmd(input logic [31:0] cmd);
    bus(1'b1, `CALSE_ADR_CMD, cmd, 4'hf);
  endtask
endmodule

bind calse_exec calse_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_done_i(instr_done_i),
  .class_b_trap_i(class_b_trap_i), .irq_block_o(irq_block_o), .flags_o(flags_o),
  .result_o(result_o)
);
